/* File: src/tac_pkg.sv */
package tac_pkg;
  // Control byte layout
  localparam int unsigned START_BIT   = 7;
  localparam int unsigned CHAN_MSB    = 6;
  localparam int unsigned CHAN_LSB    = 4;
  localparam int unsigned MODE_BIT    = 3;
  localparam int unsigned REF_SEL_BIT = 2;
  localparam int unsigned REF_PWR_BIT = 1;
  localparam int unsigned ADC_PWR_BIT = 0;
  localparam logic [2:0]  CHAN_A0_CNT = 3'h3;
  localparam logic [2:0]  CHAN_END_CNT = 3'h7;
  // Result lengths and least command spacing in serial clocks
  localparam logic [3:0]  BITS_12     = 4'hc;
  localparam logic [3:0]  BITS_8      = 4'h8;
  localparam int unsigned SPACING_12  = 15;
  localparam int unsigned SPACING_8   = 11;
  // Channel codes
  localparam logic [2:0]  CH_TEMP0    = 3'h0;
  localparam logic [2:0]  CH_YPOS     = 3'h1;
  localparam logic [2:0]  CH_VBAT     = 3'h2;
  localparam logic [2:0]  CH_Z1       = 3'h3;
  localparam logic [2:0]  CH_Z2       = 3'h4;
  localparam logic [2:0]  CH_XPOS     = 3'h5;
  localparam logic [2:0]  CH_AUX      = 3'h6;
  localparam logic [2:0]  CH_TEMP1    = 3'h7;
  // Driver switch vector {x_plus, x_minus, y_plus, y_minus}
  localparam logic [3:0]  DRV_NONE    = 4'h0;
  localparam logic [3:0]  DRV_X       = 4'hc;
  localparam logic [3:0]  DRV_Y       = 4'h3;
  localparam logic [3:0]  DRV_Z       = 4'h6;
  localparam logic [3:0]  DRV_YN      = 4'h1;
  // Register map
  localparam logic [7:0]  ADDR_RESULT = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [11:0] RESULT_RST  = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Status fields
  localparam int unsigned ST_BUSY     = 8;
  localparam int unsigned ST_REF      = 9;
  localparam int unsigned ST_ADC      = 10;
  localparam int unsigned ST_PEN_EN   = 11;
  localparam int unsigned ST_PEN_IRQ  = 12;
  localparam int unsigned ST_ACQ      = 13;
endpackage

/* File: src/tac_touch_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - First high input bit starts control byte
// - Input ignored until a start bit arrives
// - Next byte may start every 15/11 clocks
// - Channel bits with reference mode set switches
// - Bit 3 low twelve bits, high eight
// - Bit 2 high single-ended, low differential
// - Single-ended uses reference pin, else drivers
// - Power bits steer converter and reference separately
// - Converter needs no wake-up delay
// - Reference power latched as busy rises
// - Power 00: sleep between conversions, pen enabled
// - Power 01: reference off, converter on, pen off; converter here is on only while chip select is low
// - Power 10: reference on, converter down, pen on
// - Power 11: all on, pen disabled; converter here is still off while chip select is high
// - Idle low-bit zero: Y-minus on, pen sense
// - Touch pulls pen interrupt low
// - Touch measurements disconnect pen pull-up
// - Pen output low during touch measurements
// - Pen output high during other measurements
// - Low power bit one disables pen detect
// - Pen re-enabled after last result bit out
// - Acquire after channel bits, convert four later
// - Chip select high aborts, reference kept
module tac_touch_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        chip_select_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_in,
  input  wire logic        x_plus_input,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic             busy,
  output logic             busy_oe,
  output logic             pen_irq_n,
  output logic [2:0]       mux_channel,
  output logic [3:0]       driver_switches,
  output logic             ref_differential,
  output logic             ref_power_on,
  output logic             adc_power_on,
  output logic             pen_pullup_on,
  output logic             acquiring
);
  typedef enum logic [1:0] {CV_OFF, CV_START, CV_SHIFT} tac_cv_type;

  function automatic logic is_touch_chan(input logic [2:0] ch);
    is_touch_chan = (ch == tac_pkg::CH_XPOS) || (ch == tac_pkg::CH_YPOS) ||
                    (ch == tac_pkg::CH_Z1) || (ch == tac_pkg::CH_Z2);
  endfunction

  function automatic logic [3:0] drv_lookup(input logic [2:0] ch, input logic diff, input logic conv);
    logic [3:0] d;
    d = tac_pkg::DRV_NONE;
    case (ch)
      tac_pkg::CH_XPOS: d = tac_pkg::DRV_X;
      tac_pkg::CH_YPOS: d = tac_pkg::DRV_Y;
      tac_pkg::CH_Z1,
      tac_pkg::CH_Z2:   d = tac_pkg::DRV_Z;
      default:          d = tac_pkg::DRV_NONE;
    endcase
    // Single-ended drivers turn off once the sample is held
    if (conv && !diff) begin
      d = tac_pkg::DRV_NONE;
    end
    drv_lookup = d;
  endfunction

  // Two-stage synchronisers, third stage for edge detection
  logic [2:0] cs_sync_q;
  logic [2:0] clk_sync_q;
  logic [1:0] din_sync_q;
  logic [1:0] xp_sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_sync_q  <= 3'h7;
      clk_sync_q <= 3'h0;
      din_sync_q <= 2'h0;
      xp_sync_q  <= 2'h3;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], chip_select_n};
      clk_sync_q <= {clk_sync_q[1:0], serial_clock};
      din_sync_q <= {din_sync_q[0], serial_in};
      xp_sync_q  <= {xp_sync_q[0], x_plus_input};
    end
  end

  logic cs_n_s;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  assign cs_n_s    = cs_sync_q[1];
  assign cs_rise   = cs_sync_q[1] && !cs_sync_q[2];
  assign sclk_rise = clk_sync_q[1] && !clk_sync_q[2] && !cs_n_s;
  assign sclk_fall = !clk_sync_q[1] && clk_sync_q[2] && !cs_n_s;
  assign din_s     = din_sync_q[1];

  // Command receiver
  logic        rx_act_q;
  logic [2:0]  rx_cnt_q;
  logic [6:0]  rx_sr_q;
  logic [7:0]  cmd_q;
  logic        cmd_seen_q;
  logic [2:0]  chan_q;
  logic        acq_q;
  logic        byte_done;
  assign byte_done = sclk_rise && rx_act_q && (rx_cnt_q == tac_pkg::CHAN_END_CNT);

  always_ff @(posedge aclk) begin
    if (!aresetn || cs_rise) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 3'h0;
      rx_sr_q  <= 7'h00;
      acq_q    <= 1'b0;
    end else if (sclk_rise) begin
      if (!rx_act_q) begin
        if (din_s) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= 3'h1;
        end
      end else begin
        rx_sr_q  <= {rx_sr_q[5:0], din_s};
        rx_cnt_q <= rx_cnt_q + 3'h1;
        if (rx_cnt_q == tac_pkg::CHAN_A0_CNT) begin
          acq_q <= 1'b1;
        end
        if (byte_done) begin
          rx_act_q <= 1'b0;
          acq_q    <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q <= tac_pkg::CH_TEMP0;
    end else if (sclk_rise && rx_act_q && rx_cnt_q == tac_pkg::CHAN_A0_CNT) begin
      chan_q <= {rx_sr_q[1:0], din_s};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q      <= 8'h00;
      cmd_seen_q <= 1'b0;
    end else if (byte_done) begin
      cmd_q      <= {1'b1, rx_sr_q[5:0], din_s};
      cmd_seen_q <= 1'b1;
    end
  end

  // Conversion sequencer on serial clock falling edges
  tac_cv_type  cv_q;
  logic [3:0]  cv_cnt_q;
  logic [3:0]  cv_bits;
  logic [11:0] result_q;
  logic [11:0] shift_q;
  logic        busy_q;
  logic        dout_q;
  logic        ref_on_q;
  logic        pen_en_q;
  logic        cv_last;
  assign cv_bits = cmd_q[tac_pkg::MODE_BIT] ? tac_pkg::BITS_8 : tac_pkg::BITS_12;
  assign cv_last = sclk_fall && (cv_q == CV_SHIFT) && (cv_cnt_q == cv_bits - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn || cs_rise) begin
      cv_q     <= CV_OFF;
      cv_cnt_q <= 4'h0;
      busy_q   <= 1'b0;
      dout_q   <= 1'b0;
      shift_q  <= 12'h000;
    end else if (byte_done) begin
      cv_q <= CV_START;
    end else if (sclk_fall) begin
      case (cv_q)
        CV_START: begin
          busy_q   <= 1'b1;
          cv_cnt_q <= 4'h0;
          cv_q     <= CV_SHIFT;
          shift_q  <= cmd_q[tac_pkg::MODE_BIT] ? {result_q[11:4], 4'h0} : result_q;
        end
        CV_SHIFT: begin
          busy_q   <= 1'b0;
          dout_q   <= shift_q[11];
          shift_q  <= {shift_q[10:0], 1'b0};
          cv_cnt_q <= cv_cnt_q + 4'h1;
          if (cv_last) begin
            cv_q <= CV_OFF;
          end
        end
        default: begin
          dout_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_on_q <= 1'b0;
    end else if (sclk_fall && cv_q == CV_START && !byte_done && !cs_rise) begin
      ref_on_q <= cmd_q[tac_pkg::REF_PWR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pen_en_q <= 1'b1;
    end else if (byte_done && din_s) begin
      pen_en_q <= 1'b0;
    end else if (cv_last && !cs_rise && !cmd_q[tac_pkg::ADC_PWR_BIT]) begin
      pen_en_q <= 1'b1;
    end
  end

  // Analog switch control
  logic meas;
  logic touch_meas;
  logic idle_pd;
  logic converting;
  assign converting = (cv_q != CV_OFF);
  assign meas       = acq_q || converting;
  assign touch_meas = meas && is_touch_chan(chan_q);
  assign idle_pd    = !meas && !(cmd_seen_q && cmd_q[tac_pkg::ADC_PWR_BIT]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_switches  <= tac_pkg::DRV_YN;
      mux_channel      <= tac_pkg::CH_TEMP0;
      ref_differential <= 1'b0;
      pen_pullup_on    <= 1'b1;
      adc_power_on     <= 1'b0;
    end else begin
      mux_channel      <= chan_q;
      ref_differential <= !cmd_q[tac_pkg::REF_SEL_BIT];
      pen_pullup_on    <= !touch_meas;
      adc_power_on     <= !cs_n_s && !idle_pd;
      if (meas) begin
        driver_switches <= drv_lookup(chan_q, !cmd_q[tac_pkg::REF_SEL_BIT], converting);
      end else if (idle_pd) begin
        driver_switches <= tac_pkg::DRV_YN;
      end else begin
        driver_switches <= tac_pkg::DRV_NONE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pen_irq_n <= 1'b1;
    end else if (touch_meas) begin
      pen_irq_n <= 1'b0;
    end else if (meas) begin
      pen_irq_n <= 1'b1;
    end else begin
      pen_irq_n <= !(pen_en_q && !xp_sync_q[1]);
    end
  end

  assign serial_out    = dout_q;
  assign serial_out_oe = !cs_n_s;
  assign busy          = busy_q;
  assign busy_oe       = !cs_n_s;
  assign ref_power_on  = ref_on_q;
  assign acquiring     = acq_q;

  // AXI4-Lite slave
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] status_w;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign status_w = {18'h00000, acq_q, pen_irq_n, pen_en_q, adc_power_on, ref_on_q, busy_q, cmd_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tac_pkg::RESP_OKAY;
      result_q     <= tac_pkg::RESULT_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == tac_pkg::ADDR_RESULT) begin
          s_axi_bresp <= tac_pkg::RESP_OKAY;
          if (wstrb_q[0]) begin
            result_q[7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            result_q[11:8] <= wdata_q[11:8];
          end
        end else if (awaddr_q == tac_pkg::ADDR_STATUS) begin
          s_axi_bresp <= tac_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= tac_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= tac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == tac_pkg::ADDR_RESULT) begin
        s_axi_rdata <= {20'h00000, result_q};
        s_axi_rresp <= tac_pkg::RESP_OKAY;
      end else if (s_axi_araddr == tac_pkg::ADDR_STATUS) begin
        s_axi_rdata <= status_w;
        s_axi_rresp <= tac_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= tac_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  start_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sclk_rise && !rx_act_q && !din_s) |=> !rx_act_q)
    else $error("low bit started a command");

  start_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sclk_rise && !rx_act_q && din_s && !cs_rise) |=> (rx_act_q && rx_cnt_q == 3'h1))
    else $error("start bit not taken");

  ref_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy_q) |-> (ref_on_q == cmd_q[tac_pkg::REF_PWR_BIT]))
    else $error("reference power not latched at busy");

  pen_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    touch_meas |=> !pen_irq_n)
    else $error("pen output not low in touch measurement");

  pen_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (meas && !touch_meas) |=> pen_irq_n)
    else $error("pen output not high in other measurement");

  cs_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cs_rise |=> (cv_q == CV_OFF && !busy_q && !rx_act_q && $stable(ref_on_q)))
    else $error("chip select did not abort");

  pen_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (byte_done && din_s) |=> !pen_en_q)
    else $error("pen detect not disabled");

  pen_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cv_last && !cs_rise && !cmd_q[tac_pkg::ADC_PWR_BIT] && !byte_done) |=> pen_en_q)
    else $error("pen detect not re-enabled");

  yminus_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_pd && $past(idle_pd)) |-> (driver_switches == tac_pkg::DRV_YN && pen_pullup_on))
    else $error("Y-minus not on in power down");

  shift_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sclk_fall && cv_q == CV_SHIFT && !cs_rise &&
     cv_cnt_q == (cmd_q[tac_pkg::MODE_BIT] ? (tac_pkg::BITS_8 - 4'h1) : (tac_pkg::BITS_12 - 4'h1)))
    |=> (cv_q == CV_OFF))
    else $error("wrong result length");
endmodule

/* File: bench/tac_host_model.sv */
`timescale 1ns/1ps
module tac_host_model (
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic busy
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b0;
    serial_in     = 1'b0;
  end

  // Lead zeros, command, optional second command gap clocks later, then result clocks
  task automatic frame(input logic [7:0] cmd, input logic [7:0] cmd2, input int lead, input int gap,
                       input int stop, input bit hold, output logic [23:0] res, output logic bsy);
    int n;
    int nb;
    int k;
    nb = cmd[tac_pkg::MODE_BIT] ? 8 : 12;
    n = (stop > 0) ? stop : lead + gap + 8 + nb;
    res = '0;
    bsy = 1'b0;
    chip_select_n = 1'b0;
    #50;
    for (int i = 0; i <= n; i++) begin
      #20;
      k = i - lead;
      if (k >= 0 && k < 8) serial_in = cmd[7-k];
      else if (gap > 0 && k >= gap && k < gap + 8) serial_in = cmd2[7-k+gap];
      else serial_in = 1'b0;
      #35;
      k = k - 1;
      if (k == 7) bsy = busy;
      if ((k >= 8 && k < 8 + nb) || (gap > 0 && k >= gap + 8 && k < gap + 8 + nb))
        res = {res[22:0], serial_out};
      if (i == n) break;
      #7.5 serial_clock = 1'b1;
      #62.5 serial_clock = 1'b0;
    end
    if (!hold) chip_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

/* File: bench/test_tac_touch_ctrl.sv */
`timescale 1ns/1ps
module test_tac_touch_ctrl;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chip_select_n;
  logic serial_clock, serial_in, x_plus_input, serial_out, serial_out_oe, busy, busy_oe, pen_irq_n;
  logic ref_differential, ref_power_on, adc_power_on, pen_pullup_on, acquiring, bsy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cmd;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, driver_switches;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pd;
  logic [2:0]  mux_channel;
  logic [23:0] res;
  int          num_errors = 0;
  int          cmp_count = 0;
  localparam logic [11:0] RES_VAL = 12'ha5c;

  tac_touch_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n,
    .serial_clock, .serial_in, .x_plus_input, .serial_out, .serial_out_oe, .busy, .busy_oe, .pen_irq_n,
    .mux_channel, .driver_switches, .ref_differential, .ref_power_on, .adc_power_on, .pen_pullup_on,
    .acquiring);
  tac_host_model host (.chip_select_n, .serial_clock, .serial_in, .serial_out, .busy);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    int t;
    t = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && t < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      t++;
    end
    s_axi_bready <= 1'b0;
    if (!tb) chk("bvalid", 0, 1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ta, tr;
    int t;
    t = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && t < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      if (tr) chk("rresp", s_axi_rresp, er);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      t++;
    end
    s_axi_rready <= 1'b0;
    if (!tr) chk("rvalid", 0, 1);
  endtask

  initial begin
    #300000;
    chk("watchdog", 0, 1);
    tally_and_finish();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    x_plus_input = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("driver_switches", driver_switches, tac_pkg::DRV_YN);
    chk("pen_pullup_on", pen_pullup_on, 1);
    chk("serial_out_oe", serial_out_oe, 0);
    chk("busy_oe", busy_oe, 0);
    axi_rd(8'h08, rd, tac_pkg::RESP_SLVERR);
    chk("unmapped rdata", rd, 0);
    axi_wr(tac_pkg::ADDR_STATUS, 32'hffffffff, 4'hf, tac_pkg::RESP_OKAY);
    axi_wr(tac_pkg::ADDR_RESULT, 32'h00000a5c, 4'h3, tac_pkg::RESP_OKAY);
    axi_wr(tac_pkg::ADDR_RESULT, 32'h000000ff, 4'h1, tac_pkg::RESP_OKAY);
    axi_rd(tac_pkg::ADDR_RESULT, rd, tac_pkg::RESP_OKAY);
    chk("result strobe", rd, 32'h00000aff);
    axi_wr(tac_pkg::ADDR_RESULT, {20'h00000, RES_VAL}, 4'hf, tac_pkg::RESP_OKAY);
    $display("test registers done");
    // Differential X read, preceded by idle zeros
    fork
      host.frame(8'hd0, 8'h00, 3, 0, 0, 1'b0, res, bsy);
      begin
        #1150;
        chk("acquiring", acquiring, 1);
        chk("mux_channel", mux_channel, tac_pkg::CH_XPOS);
        chk("ref_differential", ref_differential, 1);
        chk("serial_out_oe", serial_out_oe, 1);
        chk("busy_oe", busy_oe, 1);
        #750;
        chk("driver_switches", driver_switches, tac_pkg::DRV_X);
        chk("pen_pullup_on", pen_pullup_on, 0);
        chk("pen_irq_n", pen_irq_n, 0);
        chk("acquiring", acquiring, 0);
      end
    join
    chk("result", res, {12'h000, RES_VAL});
    chk("busy", bsy, 1);
    @(posedge aclk) x_plus_input <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("pen_irq_n", pen_irq_n, 0);
    chk("driver_switches", driver_switches, tac_pkg::DRV_YN);
    @(posedge aclk) x_plus_input <= 1'b1;
    $display("test touch channel done");
    // Every power code, reference dropped again by a later command
    for (int p = 3; p >= 0; p--) begin
      pd = 2'(p);
      cmd = {6'b100001, pd};
      host.frame(cmd, 8'h00, 0, 0, 0, 1'b1, res, bsy);
      @(posedge aclk) x_plus_input <= 1'b0;
      repeat (10) @(posedge aclk);
      chk("result", res, {12'h000, RES_VAL});
      chk("ref_power_on", ref_power_on, pd[1]);
      chk("adc_power_on", adc_power_on, pd[0]);
      chk("pen_irq_n", pen_irq_n, pd[0]);
      axi_rd(tac_pkg::ADDR_STATUS, rd, tac_pkg::RESP_OKAY);
      chk("command byte", rd[7:0], cmd);
      chk("pen enable", rd[tac_pkg::ST_PEN_EN], !pd[0]);
      @(posedge aclk) x_plus_input <= 1'b1;
    end
    $display("test power codes done");
    // Eight-bit auxiliary reads at least spacing, panel touched
    @(posedge aclk) x_plus_input <= 1'b0;
    fork
      host.frame(8'hee, 8'hee, 0, tac_pkg::SPACING_8, 0, 1'b0, res, bsy);
      begin
        #1300;
        chk("pen_irq_n", pen_irq_n, 1);
        chk("mux_channel", mux_channel, tac_pkg::CH_AUX);
        chk("ref_differential", ref_differential, 0);
      end
    join
    chk("result", res, {8'h00, RES_VAL[11:4], RES_VAL[11:4]});
    @(posedge aclk) x_plus_input <= 1'b1;
    $display("test short spacing done");
    // Chip select rises in mid conversion
    host.frame(8'h93, 8'h00, 0, 0, 14, 1'b0, res, bsy);
    repeat (10) @(posedge aclk);
    chk("busy", busy, 0);
    chk("serial_out", serial_out, 0);
    chk("ref_power_on", ref_power_on, 1);
    chk("adc_power_on", adc_power_on, 0);
    chk("busy_oe", busy_oe, 0);
    host.frame(8'h84, 8'h00, 0, 0, 0, 1'b0, res, bsy);
    chk("result", res, {12'h000, RES_VAL});
    $display("test abort done");
    tally_and_finish();
  end
endmodule
